// ==== hdl/scr_ahb_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module scr_ahb_port
  import scr_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // AHB-Lite slave side.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Register side.
  output scr_bus_req_s req,
  input wire logic [7:0] rdata
);

  logic dph_valid_r;
  logic dph_write_r;
  logic [7:0] dph_idx_r;
  logic dph_hi_ok_r;
  logic rd_done_r;
  logic accept;

  assign accept = hsel && hready && htrans[1];

  // ==========================================================================
  // Address phase capture.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dph_valid_r <= 1'b0;
      dph_write_r <= 1'b0;
      dph_idx_r <= 8'h00;
      dph_hi_ok_r <= 1'b0;
    end else if (accept) begin
      dph_valid_r <= 1'b1;
      dph_write_r <= hwrite;
      dph_idx_r <= haddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
      dph_hi_ok_r <= (haddr[31:ADDR_IDX_MSB+1] == '0);
    end else if (hreadyout) begin
      dph_valid_r <= 1'b0;
    end
  end

  // Reads take one wait state so a write just before is already stored.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_done_r <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      if (accept) begin
        rd_done_r <= 1'b0;
      end else if (req.rd) begin
        rd_done_r <= 1'b1;
      end
      if (req.rd) begin
        hrdata <= {24'h00_0000, rdata};
      end
    end
  end

  assign req.wr = dph_valid_r && dph_write_r;
  assign req.rd = dph_valid_r && !dph_write_r && !rd_done_r;
  assign req.mapped_hi = dph_hi_ok_r;
  assign req.idx = dph_idx_r;
  assign req.wdata = hwdata[7:0];
  assign hreadyout = !req.rd;
  assign hresp = HRESP_OKAY;

endmodule : scr_ahb_port
`default_nettype wire

// ==== hdl/scr_regs.sv ====
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// [RULE1] Power-on flag reads 0 after power-on reset.
// [RULE2] Brown-out flag low after brown-out, else 1.
// [RULE3] Oscillator bit 7 selects 256k or 32k mode.
// [RULE4] Frequency codes map 16 MHz down to 32 kHz.
// [RULE5] Frequency resets to code 101, other bits 0.
// [RULE6] Bit 3 reports external clock running, read-only.
// [RULE7] Bit 2 reports high-frequency oscillator stable.
// [RULE8] Bit 1 reports low-frequency oscillator stable.
// [RULE9] Bit 0 switches system clock to internal oscillator.
// [RULE10] Timer period register, resets to all ones.
// [RULE11] Pull-up enables per pin, none for pin 5.
// [RULE12] Change-interrupt enables per pin, reset zero.
// [RULE13] Reference enable bit 7 powers reference.
// [RULE14] Reference range bit 5: 1 low, 0 high.
// [RULE15] Level field sets reference voltage fraction.
// [RULE16] Unimplemented bits ignore writes, read zero.
// [RULE17] Writes land at cycle end; status reads live.
module scr_regs
  import scr_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Observed oscillator and supply state.
  input wire logic hf_osc_stable,
  input wire logic lf_osc_stable,
  input wire logic ext_clock_running,
  input wire logic brown_out_event,
  // Oscillator control.
  output scr_osc_s osc_ctrl,
  output logic [14:0] int_osc_freq_khz,
  output logic lf_osc_selected,
  // Timer and port control.
  output logic [7:0] timer2_period,
  output logic [7:0] port_a_pullup_enable,
  output logic [7:0] port_a_change_irq_enable,
  // Comparator reference control.
  output scr_vref_s vref_ctrl,
  output logic [6:0] comparator_reference_ratio,
  // Interrupt.
  output logic irq
);

  scr_bus_req_s req;
  logic [7:0] rdata;
  logic por_n_r;
  logic bor_n_r;
  logic lf_mode_r;
  logic [2:0] freq_r;
  logic clk_sel_r;
  logic [7:0] t2_r;
  logic [7:0] pullup_r;
  logic [7:0] chg_r;
  logic vref_en_r;
  logic vref_low_r;
  logic [3:0] vref_level_r;
  logic [IRQ_W-1:0] status_r;
  logic [IRQ_W-1:0] status_nxt;
  logic [IRQ_W-1:0] mask_r;
  logic [IRQ_W-1:0] events;
  logic hf_prev_r;
  logic lf_prev_r;
  logic ext_prev_r;
  logic wr_cause;
  logic wr_osc;
  logic wr_t2;
  logic wr_pullup;
  logic wr_chg;
  logic wr_vref;
  logic wr_mask;
  logic rd_status;
  logic mapped;

  default disable iff (rst);

  // ==========================================================================
  // Bus front end.
  scr_ahb_port u_port (
    .clk_sys(clk_sys),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .req(req),
    .rdata(rdata)
  );

  assign wr_cause = req.wr && req.mapped_hi && req.idx == IDX_RESET_CAUSE;
  assign wr_osc = req.wr && req.mapped_hi && req.idx == IDX_OSC_CTRL;
  assign wr_t2 = req.wr && req.mapped_hi && req.idx == IDX_T2_PERIOD;
  assign wr_pullup = req.wr && req.mapped_hi && req.idx == IDX_PULLUP;
  assign wr_chg = req.wr && req.mapped_hi && req.idx == IDX_CHG_IRQ;
  assign wr_vref = req.wr && req.mapped_hi && req.idx == IDX_VREF;
  assign wr_mask = req.wr && req.mapped_hi && req.idx == IDX_IRQ_MASK;
  assign rd_status = req.rd && req.mapped_hi && req.idx == IDX_IRQ_STATUS;

  // ==========================================================================
  // Reset cause flags; the reset input is the power-on reset.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      por_n_r <= RST_POR_N; // [RULE1]
      bor_n_r <= RST_BOR_N;
    end else begin
      if (wr_cause) begin
        por_n_r <= req.wdata[BIT_POR_N]; // [RULE17]
      end
      // A brown-out in the write cycle wins over the software value.
      if (brown_out_event) begin
        bor_n_r <= 1'b0; // [RULE2]
      end else if (wr_cause) begin
        bor_n_r <= req.wdata[BIT_BOR_N]; // [RULE2]
      end
    end
  end

  // ==========================================================================
  // Oscillator control.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lf_mode_r <= 1'b0; // [RULE5]
      freq_r <= RST_FREQ; // [RULE5]
      clk_sel_r <= 1'b0;
    end else if (wr_osc) begin
      lf_mode_r <= req.wdata[BIT_LF_MODE]; // [RULE3]
      freq_r <= req.wdata[FREQ_MSB:FREQ_LSB];
      clk_sel_r <= req.wdata[BIT_CLK_SEL]; // [RULE9]
    end
  end

  assign osc_ctrl.lf_mode = lf_mode_r; // [RULE3]
  assign osc_ctrl.freq_sel = freq_r;
  assign osc_ctrl.clk_sel = clk_sel_r; // [RULE9]
  assign lf_osc_selected = (freq_r == FREQ_LF_CODE); // [RULE4]

  always_comb begin
    case (freq_r) // [RULE4]
      3'h7: int_osc_freq_khz = KHZ_16M;
      3'h6: int_osc_freq_khz = KHZ_8M;
      3'h5: int_osc_freq_khz = KHZ_4M;
      3'h4: int_osc_freq_khz = KHZ_2M;
      3'h3: int_osc_freq_khz = KHZ_1M;
      3'h2: int_osc_freq_khz = KHZ_500K;
      3'h1: int_osc_freq_khz = KHZ_250K;
      default: int_osc_freq_khz = KHZ_32K;
    endcase
  end

  // ==========================================================================
  // Timer period and port A controls.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      t2_r <= RST_T2_PERIOD; // [RULE10]
      pullup_r <= RST_PULLUP;
      chg_r <= RST_CHG_IRQ; // [RULE12]
    end else begin
      if (wr_t2) begin
        t2_r <= req.wdata; // [RULE10]
      end
      if (wr_pullup) begin
        pullup_r <= req.wdata & PULLUP_MASK; // [RULE11] [RULE16]
      end
      if (wr_chg) begin
        chg_r <= req.wdata; // [RULE12]
      end
    end
  end

  assign timer2_period = t2_r;
  assign port_a_pullup_enable = pullup_r;
  assign port_a_change_irq_enable = chg_r;

  // ==========================================================================
  // Comparator reference.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      vref_en_r <= 1'b0;
      vref_low_r <= 1'b0;
      vref_level_r <= 4'h0;
    end else if (wr_vref) begin
      vref_en_r <= req.wdata[BIT_VREF_EN]; // [RULE13]
      vref_low_r <= req.wdata[BIT_VREF_RANGE]; // [RULE14]
      vref_level_r <= req.wdata[LEVEL_MSB:0];
    end
  end

  assign vref_ctrl.enable = vref_en_r; // [RULE13]
  assign vref_ctrl.low_range = vref_low_r; // [RULE14]
  assign vref_ctrl.level = vref_level_r;

  // Reference as a fraction of supply, in 96ths.
  always_comb begin
    if (vref_low_r) begin
      comparator_reference_ratio = 7'(vref_level_r) * VREF_LOW_MUL; // [RULE15]
    end else begin
      comparator_reference_ratio = VREF_HIGH_BASE
        + 7'(vref_level_r) * VREF_HIGH_MUL; // [RULE15]
    end
  end

  // ==========================================================================
  // Interrupt events, sticky status, mask.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hf_prev_r <= 1'b0;
      lf_prev_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      hf_prev_r <= hf_osc_stable;
      lf_prev_r <= lf_osc_stable;
      ext_prev_r <= ext_clock_running;
    end
  end

  assign events[EV_HF_STABLE] = hf_osc_stable && !hf_prev_r;
  assign events[EV_LF_STABLE] = lf_osc_stable && !lf_prev_r;
  assign events[EV_EXT_CLK] = ext_clock_running != ext_prev_r;
  assign events[EV_BROWN_OUT] = brown_out_event;

  // A new event in the clearing read stays set.
  assign status_nxt = (rd_status ? '0 : status_r) | events;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mask_r <= '0;
    end else if (wr_mask) begin
      mask_r <= req.wdata[IRQ_W-1:0];
    end
  end

  assign irq = |(status_r & mask_r);

  // ==========================================================================
  // Read data; unmapped addresses and unused bits read zero.
  always_comb begin
    rdata = 8'h00;
    mapped = req.mapped_hi;
    case (req.idx)
      IDX_RESET_CAUSE: begin
        rdata[BIT_POR_N] = por_n_r; // [RULE1]
        rdata[BIT_BOR_N] = bor_n_r; // [RULE2] [RULE16]
      end
      IDX_OSC_CTRL: begin
        rdata[BIT_LF_MODE] = lf_mode_r;
        rdata[FREQ_MSB:FREQ_LSB] = freq_r;
        rdata[BIT_EXT_CLK] = ext_clock_running; // [RULE6] [RULE17]
        rdata[BIT_HF_STABLE] = hf_osc_stable; // [RULE7]
        rdata[BIT_LF_STABLE] = lf_osc_stable; // [RULE8]
        rdata[BIT_CLK_SEL] = clk_sel_r;
      end
      IDX_T2_PERIOD: rdata = t2_r;
      IDX_PULLUP: rdata = pullup_r;
      IDX_CHG_IRQ: rdata = chg_r;
      IDX_VREF: begin
        rdata[BIT_VREF_EN] = vref_en_r;
        rdata[BIT_VREF_RANGE] = vref_low_r;
        rdata[LEVEL_MSB:0] = vref_level_r; // [RULE16]
      end
      IDX_IRQ_STATUS: rdata[IRQ_W-1:0] = status_r;
      IDX_IRQ_MASK: rdata[IRQ_W-1:0] = mask_r;
      default: mapped = 1'b0;
    endcase
    if (!mapped) begin
      rdata = 8'h00;
    end
  end

  // ==========================================================================
  // Checks.
  a_por_hold: assert property (@(posedge clk_sys) disable iff (rst) // [RULE1]
    !wr_cause |=> por_n_r == $past(por_n_r))
    else $error("power-on flag changed without a write");

  a_bor_event_low: assert property (@(posedge clk_sys) // [RULE2]
    brown_out_event |=> !bor_n_r ##0 status_r[EV_BROWN_OUT])
    else $error("brown-out not recorded");

  a_bor_sw_set: assert property (@(posedge clk_sys) // [RULE2]
    wr_cause && !brown_out_event |=> bor_n_r == $past(req.wdata[BIT_BOR_N]))
    else $error("brown-out flag write lost");

  a_lf_mode_out: assert property (@(posedge clk_sys) // [RULE3]
    wr_osc |=> osc_ctrl.lf_mode == $past(req.wdata[BIT_LF_MODE]))
    else $error("low-frequency mode not taken");

  a_freq_code_map: assert property (@(posedge clk_sys) // [RULE4]
    (freq_r == 3'h7 |-> int_osc_freq_khz == KHZ_16M)
    and (freq_r == 3'h0 |-> lf_osc_selected && int_osc_freq_khz == KHZ_32K))
    else $error("frequency code decoded wrongly");

  a_osc_status_live: assert property (@(posedge clk_sys) // [RULE6]
    req.rd && req.mapped_hi && req.idx == IDX_OSC_CTRL |=>
      hrdata[BIT_EXT_CLK:BIT_LF_STABLE] == $past({ext_clock_running,
      hf_osc_stable, lf_osc_stable}))
    else $error("oscillator status not live");

  a_clk_sel_out: assert property (@(posedge clk_sys) // [RULE9]
    wr_osc |=> osc_ctrl.clk_sel == $past(req.wdata[BIT_CLK_SEL]))
    else $error("clock select not taken");

  a_t2_write: assert property (@(posedge clk_sys) disable iff (rst) // [RULE10]
    (wr_t2 |=> timer2_period == $past(req.wdata))
    and (!wr_t2 |=> $stable(timer2_period)))
    else $error("timer period write wrong");

  a_pullup_pin5: assert property (@(posedge clk_sys) // [RULE11]
    wr_pullup |=> !port_a_pullup_enable[BIT_PULLUP_NONE])
    else $error("pin 5 pull-up set");

  a_vref_ratio: assert property (@(posedge clk_sys) // [RULE15]
    vref_ctrl.low_range |-> comparator_reference_ratio
      == {1'b0, vref_ctrl.level, 2'b00})
    else $error("low range ratio wrong");

  a_unmapped_zero: assert property (@(posedge clk_sys) // [RULE16]
    req.rd && !mapped |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_status_sticky: assert property (@(posedge clk_sys) disable iff (rst)
    status_r[EV_HF_STABLE] && !rd_status |=> status_r[EV_HF_STABLE])
    else $error("sticky status lost");

  a_irq_level: assert property (@(posedge clk_sys) disable iff (rst)
    rd_status && events == '0 |=> irq == 1'b0)
    else $error("interrupt stayed after clearing read");

endmodule : scr_regs
`default_nettype wire

// ==== include/scr_pkg.sv ====
`default_nettype none
package scr_pkg;

  // ==========================================================================
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_RESET_CAUSE = 8'h8e;
  localparam logic [7:0] IDX_OSC_CTRL = 8'h8f;
  localparam logic [7:0] IDX_T2_PERIOD = 8'h92;
  localparam logic [7:0] IDX_PULLUP = 8'h95;
  localparam logic [7:0] IDX_CHG_IRQ = 8'h96;
  localparam logic [7:0] IDX_VREF = 8'h99;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'ha0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'ha1;

  // ==========================================================================
  // Bus geometry.
  localparam int ADDR_IDX_LSB = 2;
  localparam int ADDR_IDX_MSB = 9;
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic HRESP_OKAY = 1'b0;

  // ==========================================================================
  // Field positions.
  localparam int BIT_POR_N = 1;
  localparam int BIT_BOR_N = 0;
  localparam int BIT_LF_MODE = 7;
  localparam int FREQ_LSB = 4;
  localparam int FREQ_MSB = 6;
  localparam int BIT_EXT_CLK = 3;
  localparam int BIT_HF_STABLE = 2;
  localparam int BIT_LF_STABLE = 1;
  localparam int BIT_CLK_SEL = 0;
  localparam int BIT_VREF_EN = 7;
  localparam int BIT_VREF_RANGE = 5;
  localparam int LEVEL_MSB = 3;
  localparam int BIT_PULLUP_NONE = 5;

  // ==========================================================================
  // Reset values and implemented-bit masks.
  localparam logic RST_POR_N = 1'b0;
  localparam logic RST_BOR_N = 1'b1;
  localparam logic [2:0] RST_FREQ = 3'h5;
  localparam logic [7:0] RST_T2_PERIOD = 8'hff;
  localparam logic [7:0] RST_PULLUP = 8'hdf;
  localparam logic [7:0] PULLUP_MASK = 8'hdf;
  localparam logic [7:0] RST_CHG_IRQ = 8'h00;

  // ==========================================================================
  // Interrupt events.
  localparam int IRQ_W = 4;
  localparam int EV_HF_STABLE = 0;
  localparam int EV_LF_STABLE = 1;
  localparam int EV_EXT_CLK = 2;
  localparam int EV_BROWN_OUT = 3;

  // ==========================================================================
  // Internal oscillator frequency codes in kHz.
  localparam logic [2:0] FREQ_LF_CODE = 3'h0;
  localparam logic [14:0] KHZ_16M = 15'h3e80;
  localparam logic [14:0] KHZ_8M = 15'h1f40;
  localparam logic [14:0] KHZ_4M = 15'h0fa0;
  localparam logic [14:0] KHZ_2M = 15'h07d0;
  localparam logic [14:0] KHZ_1M = 15'h03e8;
  localparam logic [14:0] KHZ_500K = 15'h01f4;
  localparam logic [14:0] KHZ_250K = 15'h00fa;
  localparam logic [14:0] KHZ_32K = 15'h0020;

  // ==========================================================================
  // Reference ratio in 96ths of supply.
  localparam logic [6:0] VREF_LOW_MUL = 7'h04;
  localparam logic [6:0] VREF_HIGH_BASE = 7'h18;
  localparam logic [6:0] VREF_HIGH_MUL = 7'h03;

  // ==========================================================================
  // Carriers.
  typedef struct packed {
    logic wr;
    logic rd;
    logic mapped_hi;
    logic [7:0] idx;
    logic [7:0] wdata;
  } scr_bus_req_s;

  typedef struct packed {
    logic lf_mode;
    logic [2:0] freq_sel;
    logic clk_sel;
  } scr_osc_s;

  typedef struct packed {
    logic enable;
    logic low_range;
    logic [3:0] level;
  } scr_vref_s;

endpackage : scr_pkg
`default_nettype wire

// ==== verification/scr_regs_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (got), (exp)); \
  end \
end

module scr_regs_test
  import scr_pkg::*;
;
  // ==========================================================================
  // Signals.
  logic clk_sys, rst, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hf_osc_stable, lf_osc_stable, ext_clock_running, brown_out_event;
  scr_osc_s osc_ctrl;
  scr_vref_s vref_ctrl;
  logic [14:0] int_osc_freq_khz;
  logic lf_osc_selected;
  logic [7:0] timer2_period, port_a_pullup_enable, port_a_change_irq_enable;
  logic [6:0] comparator_reference_ratio;
  wire hready;
  int fails, n_compared, cycles;
  logic [14:0] khz [8] = '{KHZ_32K, KHZ_250K, KHZ_500K, KHZ_1M, KHZ_2M,
                           KHZ_4M, KHZ_8M, KHZ_16M};

  // The single slave's ready closes the bus loop.
  assign hready = hreadyout;

  scr_regs DUT (
    .clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .hf_osc_stable, .lf_osc_stable,
    .ext_clock_running, .brown_out_event, .osc_ctrl, .int_osc_freq_khz,
    .lf_osc_selected, .timer2_period, .port_a_pullup_enable,
    .port_a_change_irq_enable, .vref_ctrl, .comparator_reference_ratio, .irq
  );

  // ==========================================================================
  // Clock, timeout and closing report.
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 3000) begin
      fails++;
      stop_test();
    end
  end

  task stop_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  // ==========================================================================
  // Bus master.
  // Ready is sampled mid-cycle, where it has settled for the coming edge.
  task automatic wait_ready(output logic [31:0] d);
    logic rdy;
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      rdy = hreadyout;
      d = hrdata;
      @(posedge clk_sys);
      n++;
    end while (rdy !== 1'b1 && n < 16);
    `CHK(rdy, 1'b1);
    `CHK(hresp, HRESP_OKAY);
  endtask : wait_ready

  task automatic xfer(input logic wr_en, input logic [7:0] idx,
                      input logic [7:0] wd, output logic [31:0] rd);
    logic [31:0] d;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= wr_en;
    wait_ready(d);
    hsel <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= {24'h0, wd};
    wait_ready(rd);
    #1;
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [31:0] d;
    xfer(1'b1, idx, v, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] d;
    xfer(1'b0, idx, 8'h00, d);
    `CHK(d, {24'h0, e});
  endtask : rd_chk

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wait_cycles

  task automatic pulse_brown_out;
    brown_out_event <= 1'b1;
    @(posedge clk_sys);
    brown_out_event <= 1'b0;
    wait_cycles(2);
  endtask : pulse_brown_out

  // ==========================================================================
  // Scenarios.
  task automatic t_reset;
    `CHK(osc_ctrl, 5'b0_101_0);
    `CHK(int_osc_freq_khz, KHZ_4M);
    `CHK(timer2_period, 8'hff);
    `CHK(port_a_change_irq_enable, 8'h00);
    `CHK(vref_ctrl, 6'h00);
    rd_chk(IDX_RESET_CAUSE, 8'h01);
    rd_chk(IDX_OSC_CTRL, 8'h50);
    rd_chk(IDX_T2_PERIOD, 8'hff);
    rd_chk(IDX_PULLUP, 8'hdf);
    rd_chk(IDX_CHG_IRQ, 8'h00);
    rd_chk(IDX_VREF, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_cause;
    wr(IDX_RESET_CAUSE, 8'hfe);
    rd_chk(IDX_RESET_CAUSE, 8'h02);
    wr(IDX_RESET_CAUSE, 8'hff);
    rd_chk(IDX_RESET_CAUSE, 8'h03);
    pulse_brown_out();
    rd_chk(IDX_RESET_CAUSE, 8'h02);
    wr(IDX_RESET_CAUSE, 8'h01);
    rd_chk(IDX_RESET_CAUSE, 8'h01);
    $display("test reset cause done");
  endtask : t_cause

  task automatic t_osc;
    logic [2:0] c;
    logic [7:0] e;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      hf_osc_stable <= c[2];
      lf_osc_stable <= c[1];
      ext_clock_running <= c[0];
      wr(IDX_OSC_CTRL, {c[0], c, 3'h7, c[1]});
      `CHK(osc_ctrl, {c[0], c, c[1]});
      `CHK(int_osc_freq_khz, khz[c]);
      `CHK(lf_osc_selected, (c == 3'h0));
      e = {c[0], c, c[0], c[2], c[1], c[1]};
      rd_chk(IDX_OSC_CTRL, e);
    end
    $display("test oscillator done");
  endtask : t_osc

  task automatic vref_case(input logic [7:0] wd, input logic [7:0] e,
                           input logic [5:0] s, input logic [6:0] ratio);
    wr(IDX_VREF, wd);
    rd_chk(IDX_VREF, e);
    `CHK(vref_ctrl, s);
    `CHK(comparator_reference_ratio, ratio);
  endtask : vref_case

  task automatic t_fields;
    wr(IDX_T2_PERIOD, 8'h00);
    `CHK(timer2_period, 8'h00);
    wr(IDX_T2_PERIOD, 8'h5a);
    rd_chk(IDX_T2_PERIOD, 8'h5a);
    wr(IDX_PULLUP, 8'hff);
    `CHK(port_a_pullup_enable, 8'hdf);
    rd_chk(IDX_PULLUP, 8'hdf);
    wr(IDX_PULLUP, 8'h20);
    rd_chk(IDX_PULLUP, 8'h00);
    wr(IDX_CHG_IRQ, 8'ha5);
    `CHK(port_a_change_irq_enable, 8'ha5);
    rd_chk(IDX_CHG_IRQ, 8'ha5);
    vref_case(8'hff, 8'haf, 6'h3f, 7'h3c);
    vref_case(8'h0a, 8'h0a, 6'h0a, 7'h36);
    vref_case(8'h80, 8'h80, 6'h20, 7'h18);
    wr(8'h90, 8'h55);
    rd_chk(8'h90, 8'h00);
    rd_chk(IDX_T2_PERIOD, 8'h5a);
    $display("test fields done");
  endtask : t_fields

  task automatic t_irq;
    logic [31:0] d;
    hf_osc_stable <= 1'b0;
    lf_osc_stable <= 1'b0;
    ext_clock_running <= 1'b0;
    wait_cycles(2);
    xfer(1'b0, IDX_IRQ_STATUS, 8'h00, d);
    wr(IDX_IRQ_MASK, 8'h00);
    pulse_brown_out();
    `CHK(irq, 1'b0);
    rd_chk(IDX_IRQ_STATUS, 8'h08);
    rd_chk(IDX_IRQ_STATUS, 8'h00);
    rd_chk(IDX_RESET_CAUSE, 8'h00);
    wr(IDX_IRQ_MASK, 8'h0f);
    rd_chk(IDX_IRQ_MASK, 8'h0f);
    hf_osc_stable <= 1'b1;
    lf_osc_stable <= 1'b1;
    wait_cycles(2);
    `CHK(irq, 1'b1);
    rd_chk(IDX_IRQ_STATUS, 8'h03);
    `CHK(irq, 1'b0);
    wr(IDX_IRQ_MASK, 8'h01);
    lf_osc_stable <= 1'b0;
    wait_cycles(1);
    lf_osc_stable <= 1'b1;
    ext_clock_running <= 1'b1;
    wait_cycles(2);
    `CHK(irq, 1'b0);
    rd_chk(IDX_IRQ_STATUS, 8'h06);
    $display("test interrupt done");
  endtask : t_irq

  // A second reset in mid-run must bring back the power-on values.
  task automatic t_rerst;
    wr(IDX_RESET_CAUSE, 8'h03);
    wr(IDX_T2_PERIOD, 8'h12);
    rst <= 1'b1;
    wait_cycles(2);
    rst <= 1'b0;
    wait_cycles(1);
    `CHK(timer2_period, 8'hff);
    `CHK(irq, 1'b0);
    rd_chk(IDX_RESET_CAUSE, 8'h01);
    $display("test second reset done");
  endtask : t_rerst

  // ==========================================================================
  // Main sequence.
  initial begin
    fails = 0;
    n_compared = 0;
    cycles = 0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = HTRANS_IDLE;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    hf_osc_stable = 1'b0;
    lf_osc_stable = 1'b0;
    ext_clock_running = 1'b0;
    brown_out_event = 1'b0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    wait_cycles(1);
    t_reset();
    t_cause();
    t_osc();
    t_fields();
    t_irq();
    t_rerst();
    stop_test();
  end

endmodule : scr_regs_test
`default_nettype wire
